// File: logic/swct_map.vh
// Constants of the standby wake cascade timer
// How it works
// R1: Two 16-bit counter channels chain into one 32-bit counter.
// R2: In cascade, each first-stage underflow decrements the second stage.
// R3: First stage counts sub oscillator or low-speed internal oscillator ticks.
// R4: Second-stage underflow raises an interrupt that wakes from low power.
// R5: One stage at 32.768 kHz gives about 2.0 s maximum period.
// R6: Cascade reaches about 2184.5 minutes at 30.517 us resolution.
// R7: Calendar alarm is an alternative wake source with 1 s resolution.
// R8: Second-stage interrupt alternates the device between standby and snooze.
// R9: Calendar alarm interrupt cancels standby back to normal.
// R10: External pin interrupt cancels sleep and deep standby.
// R11: System clock source may switch at run time without reset.
// R12: Controller waits for oscillator stabilisation before using a new clock.
// R13: Deep standby cuts internal module power and resets I/O port states.
// R14: Any enabled interrupt cancels sleep.
// R15: Sleep and standby modes entered by wait-for-interrupt with chosen mode.
// R16: Each stage reloads its period on underflow and keeps counting.
// R17: Counters, source choice and cascade setting keep state in standby.
`ifndef SWCT_MAP_VH
`define SWCT_MAP_VH

`define SWCT_STAGE_WIDTH   16
`define SWCT_PERIOD_RESET  16'hffff
`define SWCT_SRC_SUB_OSC   1'b0
`define SWCT_SRC_LOW_OSC   1'b1

// Power modes, also the mode select codes except snooze
`define SWCT_MODE_NORMAL   3'h0
`define SWCT_MODE_SLEEP    3'h1
`define SWCT_MODE_STANDBY  3'h2
`define SWCT_MODE_SNOOZE   3'h3
`define SWCT_MODE_DEEP     3'h4

// System clock sources
`define SWCT_CLK_MAIN      3'h0
`define SWCT_CLK_HIGH      3'h1
`define SWCT_CLK_MEDIUM    3'h2
`define SWCT_CLK_LOW       3'h3
`define SWCT_CLK_SUB       3'h4

`endif

// File: logic/swct_stage.v
// One reloading down-counter stage of the wake timer
`include "swct_map.vh"

module swct_stage
#(
   parameter WIDTH = `SWCT_STAGE_WIDTH
)
(
   input  wire             clk_sys,
   input  wire             rst,
   input  wire             run,
   input  wire             tick,
   input  wire             load,
   input  wire [WIDTH-1:0] period,
   output reg  [WIDTH-1:0] count,
   output reg              underflow
);

   always @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         count     <= {WIDTH{1'b1}};
         underflow <= 1'b0;
      end
      else
      begin
         underflow <= 1'b0;
         if (load)
            count <= period;
         else if (run && tick)
         begin
            if (count == {WIDTH{1'b0}})
            begin
               count     <= period; // R16
               underflow <= 1'b1;
            end
            else
               count <= count - 1'b1;
         end
      end
   end

endmodule // swct_stage

// File: logic/swct_top.v
// Standby wake cascade timer with power mode sequencing
`include "swct_map.vh"

module swct_top
#(
   parameter WIDTH = `SWCT_STAGE_WIDTH
)
(
   input  wire             clk_sys,
   input  wire             rst,
   input  wire             sub_osc_tick,
   input  wire             low_speed_osc_tick,
   input  wire             count_src_sel,
   input  wire             cascade_en,
   input  wire             timer_start,
   input  wire             timer_load,
   input  wire [WIDTH-1:0] first_period,
   input  wire [WIDTH-1:0] second_period,
   input  wire [2:0]       standby_control_reg,
   input  wire             wait_for_interrupt,
   input  wire             snooze_en,
   input  wire             calendar_alarm,
   input  wire             external_wake_interrupt,
   input  wire             other_irq,
   input  wire             clk_switch_req,
   input  wire [2:0]       clk_switch_src,
   input  wire             clk_stable,
   output reg  [2:0]       power_mode,
   output reg              wake_irq,
   output reg              second_underflow_irq,
   output reg  [2*WIDTH-1:0] cascade_count,
   output reg              module_power_off,
   output reg              io_port_reset,
   output reg              cpu_run,
   output reg  [2:0]       sys_clk_src,
   output reg              first_underflow
);

   // ************************************************
   // Count source selection
   // ************************************************
   wire             src_tick;
   wire [WIDTH-1:0] first_count;
   wire [WIDTH-1:0] second_count;
   wire             first_uf;
   wire             second_uf;
   wire             second_tick;
   reg              running;

   // R3
   assign src_tick = (count_src_sel == `SWCT_SRC_LOW_OSC) ? low_speed_osc_tick
                                                          : sub_osc_tick;

   // R2: cascade counts first-stage underflows instead of source ticks
   assign second_tick = cascade_en ? first_uf : src_tick;

   // ************************************************
   // Run state
   // ************************************************
   // R17: run state depends only on reset and control, never on power mode
   always @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         running <= 1'b0;
      else if (timer_load)
         running <= 1'b0;
      else if (timer_start)
         running <= 1'b1;
   end

   // ************************************************
   // Counter stages
   // ************************************************
   wire [2*WIDTH-1:0] stage_period;
   wire [2*WIDTH-1:0] stage_count;
   wire [1:0]         stage_tick;
   wire [1:0]         stage_uf;

   // Stage 0 counts the chosen source, stage 1 follows cascade_en
   assign stage_period = {second_period, first_period};
   assign stage_tick   = {second_tick, src_tick};
   assign first_count  = stage_count[WIDTH-1:0];
   assign second_count = stage_count[2*WIDTH-1:WIDTH];
   assign first_uf     = stage_uf[0];
   assign second_uf    = stage_uf[1];

   // R1 R5 R6
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1)
      begin : g_stage
         swct_stage #(.WIDTH(WIDTH)) u_stage
         (
            .clk_sys   (clk_sys),
            .rst       (rst),
            .run       (running),
            .tick      (stage_tick[gi]),
            .load      (timer_load),
            .period    (stage_period[gi*WIDTH +: WIDTH]),
            .count     (stage_count[gi*WIDTH +: WIDTH]),
            .underflow (stage_uf[gi])
         );
      end
   endgenerate

   // ************************************************
   // Power mode states
   // ************************************************
   localparam [2:0] ST_NORMAL  = `SWCT_MODE_NORMAL;
   localparam [2:0] ST_SLEEP   = `SWCT_MODE_SLEEP;
   localparam [2:0] ST_STANDBY = `SWCT_MODE_STANDBY;
   localparam [2:0] ST_SNOOZE  = `SWCT_MODE_SNOOZE;
   localparam [2:0] ST_DEEP    = `SWCT_MODE_DEEP;

   // ************************************************
   // Decoding helpers
   // ************************************************
   // Codes other than sleep, standby and deep keep the core running
   function [2:0] entry_mode;
      input [2:0] sel;
      begin
         case (sel)
            ST_SLEEP:   entry_mode = ST_SLEEP;
            ST_STANDBY: entry_mode = ST_STANDBY;
            ST_DEEP:    entry_mode = ST_DEEP;
            default:    entry_mode = ST_NORMAL;
         endcase
      end
   endfunction

   // Alarm or pin cancel standby and snooze alike
   function standby_cancel;
      input alarm;
      input pin;
      begin
         standby_cancel = alarm | pin;
      end
   endfunction

   // Power gating follows the deep standby state
   function in_deep;
      input [2:0] mode;
      begin
         in_deep = (mode == ST_DEEP);
      end
   endfunction

   // ************************************************
   // Power mode sequencer
   // ************************************************
   reg [2:0] next_mode;
   reg       any_irq;

   // In standby and snooze, alarm and pin outrank a coincident underflow
   always @*
   begin
      any_irq   = second_uf | calendar_alarm | external_wake_interrupt | other_irq;
      next_mode = power_mode;
      case (power_mode)
         ST_NORMAL:
         begin
            if (wait_for_interrupt) // R15
            begin
               next_mode = entry_mode(standby_control_reg);
            end
         end
         ST_SLEEP:
         begin
            if (any_irq) // R14 R10
            begin
               next_mode = ST_NORMAL;
            end
         end
         ST_STANDBY:
         begin
            if (standby_cancel(calendar_alarm, external_wake_interrupt)) // R9 R7
            begin
               next_mode = ST_NORMAL;
            end
            else if (second_uf && snooze_en) // R8
            begin
               next_mode = ST_SNOOZE;
            end
            else if (second_uf) // R4
            begin
               next_mode = ST_NORMAL;
            end
         end
         ST_SNOOZE:
         begin
            if (standby_cancel(calendar_alarm, external_wake_interrupt))
            begin
               next_mode = ST_NORMAL;
            end
            else if (second_uf) // R8
            begin
               next_mode = ST_STANDBY;
            end
         end
         // Only the pin and the wake timer reach into deep standby
         ST_DEEP:
         begin
            if (external_wake_interrupt || second_uf) // R10 R4
            begin
               next_mode = ST_NORMAL;
            end
         end
         default:
         begin
            next_mode = ST_NORMAL;
         end
      endcase
   end

   // ************************************************
   // Mode register
   // ************************************************
   always @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         power_mode <= ST_NORMAL;
      else
         power_mode <= next_mode;
   end

   // ************************************************
   // Wake pulse and core run
   // ************************************************
   // Wake pulse marks every return to normal, whatever the cause
   always @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         wake_irq <= 1'b0;
         cpu_run  <= 1'b1;
      end
      else
      begin
         wake_irq <= (next_mode == ST_NORMAL) && (power_mode != ST_NORMAL);
         cpu_run  <= (next_mode == ST_NORMAL); // R15
      end
   end

   // ************************************************
   // Count mirror
   // ************************************************
   // Trails the stage counters by one cycle
   always @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         cascade_count <= {(2*WIDTH){1'b1}};
      else
         cascade_count <= {second_count, first_count}; // R1
   end

   // ************************************************
   // Underflow pulses
   // ************************************************
   // One-cycle pulses, a cycle after the stage underflow
   always @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         second_underflow_irq <= 1'b0;
         first_underflow      <= 1'b0;
      end
      else
      begin
         second_underflow_irq <= second_uf; // R4
         first_underflow      <= first_uf;
      end
   end

   // ************************************************
   // Deep standby power gating
   // ************************************************
   always @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         module_power_off <= 1'b0;
         io_port_reset    <= 1'b0;
      end
      else
      begin
         module_power_off <= in_deep(next_mode); // R13
         io_port_reset    <= in_deep(next_mode); // R13
      end
   end

   // ************************************************
   // System clock source
   // ************************************************
   // R11 R12: switch only in normal and once the new source reports stable
   // A request while asleep is dropped, not queued
   always @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         sys_clk_src <= `SWCT_CLK_MAIN;
      else if (clk_switch_req && clk_stable && power_mode == ST_NORMAL)
         sys_clk_src <= clk_switch_src;
   end

endmodule // swct_top

// File: bench/swct_sva.sv
// Concurrent checks on the wake timer ports
module swct_sva
(
   input wire       clk_sys,
   input wire       rst,
   input wire       wait_for_interrupt,
   input wire [2:0] standby_control_reg,
   input wire       calendar_alarm,
   input wire       external_wake_interrupt,
   input wire       other_irq,
   input wire       clk_switch_req,
   input wire [2:0] clk_switch_src,
   input wire       clk_stable,
   input wire [2:0] power_mode,
   input wire       wake_irq,
   input wire       module_power_off,
   input wire       io_port_reset,
   input wire       cpu_run,
   input wire [2:0] sys_clk_src
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence s_wfi(logic [2:0] m);
      power_mode == 3'h0 && wait_for_interrupt && standby_control_reg == m;
   endsequence
   property p_sleep_in; s_wfi(3'h1) |=> power_mode == 3'h1; endproperty
   a_sleep_in: assert property (p_sleep_in) else $error("no sleep entry");
   property p_deep_in; s_wfi(3'h4) |=> power_mode == 3'h4; endproperty
   a_deep_in: assert property (p_deep_in) else $error("no deep entry");
   property p_deep_pwr; power_mode == 3'h4 |-> module_power_off && io_port_reset; endproperty
   a_deep_pwr: assert property (p_deep_pwr) else $error("deep power cut missing");
   property p_cpu; power_mode != 3'h0 |-> !cpu_run; endproperty
   a_cpu: assert property (p_cpu) else $error("core runs in low power");
   property p_alarm; power_mode == 3'h2 && calendar_alarm |=> power_mode == 3'h0; endproperty
   a_alarm: assert property (p_alarm) else $error("alarm did not wake");
   property p_ext; power_mode == 3'h4 && external_wake_interrupt |=> power_mode == 3'h0; endproperty
   a_ext: assert property (p_ext) else $error("pin did not wake deep");
   property p_sleep_out; power_mode == 3'h1 && other_irq |=> power_mode == 3'h0; endproperty
   a_sleep_out: assert property (p_sleep_out) else $error("irq did not end sleep");
   property p_wake; power_mode == 3'h0 && $past(power_mode) != 3'h0 |-> wake_irq; endproperty
   a_wake: assert property (p_wake) else $error("no wake pulse");
   property p_swap;
      clk_switch_req && clk_stable && power_mode == 3'h0 |=> sys_clk_src == $past(clk_switch_src);
   endproperty
   a_swap: assert property (p_swap) else $error("clock not switched");
   property p_hold; clk_switch_req && !clk_stable |=> $stable(sys_clk_src); endproperty
   a_hold: assert property (p_hold) else $error("unsettled clock taken");
endmodule // swct_sva

// File: bench/swct_core_model.sv
// Core side model: oscillator settling and wake counting
module swct_core_model #(parameter STAB = 8)
(
   input  wire  clk_sys,
   input  wire  rst,
   input  wire  osc_start,
   input  wire  wake_irq,
   output logic clk_stable,
   output int   wake_count
);
   timeunit 1ns;
   timeprecision 1ps;
   int settle;
   always @(posedge clk_sys or posedge rst)
   begin
      if (rst || osc_start)
         settle <= 0;
      else if (settle < STAB)
         settle <= settle + 1;
      if (rst)
         wake_count <= 0;
      else if (wake_irq)
         wake_count <= wake_count + 1;
   end
   assign clk_stable = settle == STAB && !osc_start;
endmodule // swct_core_model

// File: bench/tb_standby_wake_cascade_timer.sv
// Self-checking bench for the wake cascade timer
module tb_standby_wake_cascade_timer;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys, rst, sub_osc_tick, low_speed_osc_tick, count_src_sel, cascade_en;
   logic timer_start, timer_load, wait_for_interrupt, snooze_en, calendar_alarm, other_irq;
   logic external_wake_interrupt, clk_switch_req, clk_stable, osc_start, wake_irq, cpu_run;
   logic second_underflow_irq, module_power_off, io_port_reset, first_underflow;
   logic [15:0] first_period, second_period;
   logic [2:0] standby_control_reg, clk_switch_src, power_mode, sys_clk_src;
   logic [31:0] cascade_count;
   int n_mismatch, num_checks, n_first, n_second, wake_count;
   swct_top swct_top_i (.clk_sys(clk_sys), .rst(rst), .sub_osc_tick(sub_osc_tick),
      .low_speed_osc_tick(low_speed_osc_tick), .count_src_sel(count_src_sel),
      .cascade_en(cascade_en), .timer_start(timer_start), .timer_load(timer_load),
      .first_period(first_period), .second_period(second_period), .snooze_en(snooze_en),
      .standby_control_reg(standby_control_reg), .wait_for_interrupt(wait_for_interrupt),
      .calendar_alarm(calendar_alarm), .external_wake_interrupt(external_wake_interrupt),
      .other_irq(other_irq), .clk_switch_req(clk_switch_req), .clk_stable(clk_stable),
      .clk_switch_src(clk_switch_src), .power_mode(power_mode), .wake_irq(wake_irq),
      .second_underflow_irq(second_underflow_irq), .cascade_count(cascade_count),
      .module_power_off(module_power_off), .io_port_reset(io_port_reset), .cpu_run(cpu_run),
      .sys_clk_src(sys_clk_src), .first_underflow(first_underflow));
   swct_core_model swct_core_model_i (.clk_sys(clk_sys), .rst(rst), .osc_start(osc_start),
      .wake_irq(wake_irq), .clk_stable(clk_stable), .wake_count(wake_count));
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         n_first <= 0;
         n_second <= 0;
      end
      else
      begin
         n_first <= n_first + first_underflow;
         n_second <= n_second + second_underflow_irq;
      end
   end
   task check(input logic [31:0] seen, exp, input string what);
      num_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task test_done;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic pulse(ref logic s);
      @(negedge clk_sys) s = 1;
      @(negedge clk_sys) s = 0;
      repeat (6) @(negedge clk_sys);
   endtask
   task automatic load(input logic [15:0] a, b);
      first_period = a;
      second_period = b;
      pulse(timer_load);
      pulse(timer_start);
   endtask
   task automatic enter(input logic [2:0] m);
      standby_control_reg = m;
      pulse(wait_for_interrupt);
      check(power_mode, m, "entered mode");
      check(cpu_run, 0, "core stopped");
   endtask
   task t_cascade;
      load(16'h0002, 16'h0001);
      check(cascade_count, 32'h00010002, "loaded count");
      repeat (3) pulse(sub_osc_tick);
      check(n_first, 0, "unselected source");
      repeat (12) pulse(low_speed_osc_tick);
      check(n_first, 4, "first underflows");
      check(n_second, 2, "second underflows");
      {count_src_sel, cascade_en} = 2'b00;
      repeat (3) pulse(sub_osc_tick);
      check(n_first, 5, "sub source underflows");
      check(n_second, 3, "uncascaded underflows");
      {count_src_sel, cascade_en} = 2'b11;
   endtask
   task t_standby;
      load(16'h0000, 16'h0000);
      enter(3'h2);
      pulse(low_speed_osc_tick);
      check(power_mode, 3'h0, "timer wake");
      check(wake_count, 1, "wake pulses");
      snooze_en = 1;
      enter(3'h2);
      pulse(low_speed_osc_tick);
      check(power_mode, 3'h3, "snooze request");
      pulse(low_speed_osc_tick);
      check(power_mode, 3'h2, "snooze end");
      pulse(calendar_alarm);
      check(power_mode, 3'h0, "alarm wake");
   endtask
   task t_deep_sleep;
      load(16'h0003, 16'h0005);
      enter(3'h4);
      check({module_power_off, io_port_reset}, 2'b11, "deep cut");
      pulse(low_speed_osc_tick);
      check(cascade_count, 32'h00050002, "count in deep");
      pulse(external_wake_interrupt);
      check(power_mode, 3'h0, "pin wake");
      enter(3'h1);
      pulse(other_irq);
      check(power_mode, 3'h0, "sleep end");
   endtask
   task t_clock;
      clk_switch_src = 3'h3;
      pulse(osc_start);
      pulse(clk_switch_req);
      check(sys_clk_src, 3'h0, "unsettled switch");
      for (int c = 0; c < 5; c++)
      begin
         clk_switch_src = c[2:0];
         pulse(osc_start);
         repeat (20) if (!clk_stable) @(negedge clk_sys);
         pulse(clk_switch_req);
         check(sys_clk_src, c[2:0], "clock source");
      end
   endtask
   initial
   begin
      clk_sys = 0;
      forever #20 clk_sys = ~clk_sys;
   end
   initial
   begin
      #(40 * 6000);
      n_mismatch++;
      test_done;
   end
   initial
   begin
      {sub_osc_tick, low_speed_osc_tick, timer_start, timer_load, wait_for_interrupt} = 0;
      {snooze_en, calendar_alarm, other_irq, external_wake_interrupt, clk_switch_req} = 0;
      {osc_start, n_mismatch, num_checks} = 0;
      {count_src_sel, cascade_en, first_period, second_period} = {2'b11, 32'h0};
      {standby_control_reg, clk_switch_src} = 0;
      rst = 1;
      repeat (12) @(negedge clk_sys);
      rst = 0;
      check(cascade_count, 32'hffffffff, "full period");
      t_cascade;
      t_standby;
      t_deep_sleep;
      t_clock;
      test_done;
   end
endmodule // tb_standby_wake_cascade_timer
bind swct_top swct_sva swct_sva_i (.clk_sys(clk_sys), .rst(rst), .other_irq(other_irq),
   .wait_for_interrupt(wait_for_interrupt), .standby_control_reg(standby_control_reg),
   .calendar_alarm(calendar_alarm), .external_wake_interrupt(external_wake_interrupt),
   .clk_switch_req(clk_switch_req), .clk_switch_src(clk_switch_src), .cpu_run(cpu_run),
   .clk_stable(clk_stable), .power_mode(power_mode), .wake_irq(wake_irq),
   .module_power_off(module_power_off), .io_port_reset(io_port_reset),
   .sys_clk_src(sys_clk_src));
